//--- core/aoip_pkg.sv
package aoip_pkg;
  // pixel and line geometry
  localparam int PIX_BITS = 12;
  localparam int LINE_PIX = 16384;
  localparam int AREA_NUM = 4;
  localparam int LANE_BITS = 2;
  localparam int FIFO_DEPTH = 32;

  typedef logic [13:0] aoip_col_t;
  typedef logic [14:0] aoip_wid_t;
  typedef logic [16:0] aoip_sum_t;
  typedef logic [18:0] aoip_byte_t;

  // area limits
  localparam aoip_sum_t LINE_WIDTH = 17'h04000;
  localparam aoip_sum_t MIN_AREA_W = 17'h00060;
  localparam aoip_sum_t MIN_TOTAL_W = 17'h00400;
  localparam aoip_sum_t MAX_TOTAL_W = 17'h04000;
  localparam aoip_sum_t STEP_MASK = 17'h1ffe0;
  localparam aoip_sum_t STEP_ROUND = 17'h0001f;
  localparam aoip_col_t MAX_START = 14'h3fa0;
  localparam aoip_col_t LAST_COL = 14'h3fff;
  localparam logic [2:0] MIN_COUNT = 3'h1;
  localparam logic [2:0] MAX_COUNT = 3'h4;

  // output lane budget
  localparam aoip_byte_t PIX_BYTES = 19'h00002;
  localparam aoip_byte_t LANE_COUNT = 19'h00004;
  localparam aoip_byte_t LANE_ROUND = 19'h00003;
  localparam aoip_byte_t LANE_BYTES_MAX = 19'h02000;

  // reset values
  localparam logic [2:0] RST_COUNT = MIN_COUNT;
  localparam aoip_col_t RST_START = 14'h0000;
  localparam aoip_wid_t RST_WIDTH_FIRST = aoip_wid_t'(LINE_WIDTH);
  localparam aoip_wid_t RST_WIDTH_REST = aoip_wid_t'(MIN_AREA_W);

  typedef struct packed {
    aoip_col_t start;
    aoip_wid_t width;
  } aoip_area_t;

  typedef struct packed {
    logic last;
    logic [LANE_BITS-1:0] lane;
    logic [PIX_BITS-1:0] pix;
  } aoip_beat_t;
endpackage

//--- core/aoip_fifo.sv
module aoip_fifo #(
  parameter int WIDTH = 15,
  parameter int DEPTH = 32
) (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic in_ready_out,
  output logic out_valid_out,
  output logic [WIDTH-1:0] out_data_out,
  input wire logic out_ready_in
);
  localparam int PW = $clog2(DEPTH);
  localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

  logic [WIDTH-1:0] mem [0:DEPTH-1];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [PW:0] cnt_reg;
  logic wr;
  logic rd;

  // honest full: ready only while the array has room
  assign in_ready_out = (cnt_reg != FULL_CNT);
  assign wr = in_valid_in && in_ready_out;
  assign rd = (cnt_reg != '0) && (!out_valid_out || out_ready_in);

  // storage array
  always_ff @(posedge ref_clk_in)
  begin
    if (wr)
    begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // pointers and fill count
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      if (wr)
      begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (rd)
      begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      if (wr && !rd)
      begin
        cnt_reg <= cnt_reg + 1'b1;
      end
      else if (rd && !wr)
      begin
        cnt_reg <= cnt_reg - 1'b1;
      end
    end
  end

  // registered output stage, stalls while the drain side holds ready low
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      out_valid_out <= 1'b0;
      out_data_out <= '0;
    end
    else if (rd)
    begin
      out_valid_out <= 1'b1;
      out_data_out <= mem[rd_ptr_reg];
    end
    else if (out_ready_in)
    begin
      out_valid_out <= 1'b0;
    end
  end
endmodule

//--- core/aoip_packer.sv
// Functional notes
// - pixels outside every area never leave
// - packed line width equals summed area widths
// - area count clamped to one through four
// - each area at least 96 pixels wide
// - summed width at least 1024 pixels
// - summed width at most 16384 pixels
// - at most 8k bytes per output lane
// - widths rounded to 32 pixel steps
// - start column limited to 0..16288
// - overlapping areas each output their pixels
// - raised start shrinks width to fit line
// - areas interact only through total width
// - areas emitted in index order from column zero
// - lowered count pulls selector into range
// - illegal requests clamped, never applied raw
// - capture state is readable
module aoip_packer (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic area_count_wr_in,
  input wire logic [2:0] area_count_in,
  input wire logic area_index_select_wr_in,
  input wire logic [1:0] area_index_select_in,
  input wire logic area_start_column_wr_in,
  input wire logic [13:0] area_start_column_in,
  input wire logic area_pixel_width_wr_in,
  input wire logic [14:0] area_pixel_width_in,
  input wire logic begin_capture_cmd_in,
  input wire logic halt_capture_cmd_in,
  input wire logic pix_valid_in,
  input wire logic [11:0] pix_data_in,
  output logic pix_ready_out,
  output logic out_valid_out,
  output aoip_pkg::aoip_beat_t out_beat_out,
  input wire logic out_ready_in,
  output logic capture_state_out,
  output logic cfg_refused_out,
  output logic [2:0] area_count_out,
  output logic [1:0] area_index_select_out,
  output logic [13:0] area_start_column_out,
  output logic [14:0] area_pixel_width_out,
  output logic [16:0] packed_width_out
);
  typedef enum logic [1:0] {ST_IDLE, ST_FILL, ST_EMIT} aoip_state_t;

  logic [aoip_pkg::PIX_BITS-1:0] line_mem [0:aoip_pkg::LINE_PIX-1];
  aoip_pkg::aoip_area_t area_reg [0:aoip_pkg::AREA_NUM-1];
  logic [2:0] count_reg;
  logic [1:0] sel_reg;
  aoip_state_t state_reg;
  logic capture_reg;
  logic halt_pend_reg;
  logic pix_ready_reg;
  logic refused_reg;
  aoip_pkg::aoip_col_t fill_col_reg;
  aoip_pkg::aoip_col_t rd_col_reg;
  aoip_pkg::aoip_wid_t remain_reg;
  aoip_pkg::aoip_wid_t out_col_reg;
  logic [1:0] area_ptr_reg;
  logic [1:0] ptr_next;
  aoip_pkg::aoip_col_t start_rb_reg;
  aoip_pkg::aoip_wid_t width_rb_reg;
  aoip_pkg::aoip_sum_t packed_reg;
  aoip_pkg::aoip_sum_t total_sum;
  aoip_pkg::aoip_sum_t others_sum;
  aoip_pkg::aoip_col_t start_clamped;
  aoip_pkg::aoip_beat_t beat;
  logic [2:0] count_new;
  logic cfg_wr;
  logic take;
  logic push;
  logic fifo_ready;
  logic last_beat;
  logic limits_ok;

  // fit a requested width into step, per-area and total limits
  function automatic aoip_pkg::aoip_wid_t fit_width(input aoip_pkg::aoip_wid_t req,
    input aoip_pkg::aoip_col_t start, input aoip_pkg::aoip_sum_t others);
    aoip_pkg::aoip_sum_t hi;
    aoip_pkg::aoip_sum_t lo;
    aoip_pkg::aoip_sum_t room;
    aoip_pkg::aoip_sum_t w;
    hi = aoip_pkg::LINE_WIDTH - aoip_pkg::aoip_sum_t'(start);
    room = (others < aoip_pkg::MAX_TOTAL_W) ? aoip_pkg::MAX_TOTAL_W - others : 17'h00000;
    if (room < hi)
    begin
      hi = room;
    end
    hi = hi & aoip_pkg::STEP_MASK;
    lo = aoip_pkg::MIN_AREA_W;
    if (others + lo < aoip_pkg::MIN_TOTAL_W)
    begin
      lo = (aoip_pkg::MIN_TOTAL_W - others + aoip_pkg::STEP_ROUND) & aoip_pkg::STEP_MASK;
    end
    w = aoip_pkg::aoip_sum_t'(req) & aoip_pkg::STEP_MASK;
    if (w < lo)
    begin
      w = lo;
    end
    if (w > hi)
    begin
      w = hi;
    end
    if (w < aoip_pkg::MIN_AREA_W)
    begin
      w = aoip_pkg::MIN_AREA_W;
    end
    return w[14:0];
  endfunction

  // bytes that the fullest lane carries for a packed line
  function automatic aoip_pkg::aoip_byte_t lane_bytes(input aoip_pkg::aoip_sum_t total);
    return (aoip_pkg::aoip_byte_t'(total) * aoip_pkg::PIX_BYTES + aoip_pkg::LANE_ROUND) / aoip_pkg::LANE_COUNT;
  endfunction

  // summed width of the active areas
  always_comb
  begin
    total_sum = 17'h00000;
    for (int i = 0; i < aoip_pkg::AREA_NUM; i++)
    begin
      if (3'(i) < count_reg)
      begin
        total_sum = total_sum + aoip_pkg::aoip_sum_t'(area_reg[i].width);
      end
    end
  end

  // clamps for area writes and limits that gate capture start
  assign others_sum = total_sum - aoip_pkg::aoip_sum_t'(area_reg[sel_reg].width);
  assign limits_ok = (total_sum >= aoip_pkg::MIN_TOTAL_W) && (total_sum <= aoip_pkg::MAX_TOTAL_W)
    && (lane_bytes(total_sum) <= aoip_pkg::LANE_BYTES_MAX);
  assign start_clamped = (area_start_column_in > aoip_pkg::MAX_START) ? aoip_pkg::MAX_START : area_start_column_in;
  assign count_new = (area_count_in < aoip_pkg::MIN_COUNT) ? aoip_pkg::MIN_COUNT :
    (area_count_in > aoip_pkg::MAX_COUNT) ? aoip_pkg::MAX_COUNT : area_count_in;
  assign cfg_wr = area_count_wr_in || area_index_select_wr_in || area_start_column_wr_in || area_pixel_width_wr_in;

  // area configuration, one write per cycle, count first
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      count_reg <= aoip_pkg::RST_COUNT;
      sel_reg <= 2'h0;
      refused_reg <= 1'b0;
      for (int i = 0; i < aoip_pkg::AREA_NUM; i++)
      begin
        area_reg[i].start <= aoip_pkg::RST_START;
        area_reg[i].width <= (i == 0) ? aoip_pkg::RST_WIDTH_FIRST : aoip_pkg::RST_WIDTH_REST;
      end
    end
    else
    begin
      refused_reg <= capture_reg && cfg_wr;
      if (!capture_reg)
      begin
        if (area_count_wr_in)
        begin
          count_reg <= count_new;
          if ({1'b0, sel_reg} >= count_new)
          begin
            sel_reg <= 2'(count_new - 3'h1);
          end
        end
        else if (area_index_select_wr_in)
        begin
          sel_reg <= ({1'b0, area_index_select_in} < count_reg) ? area_index_select_in : 2'(count_reg - 3'h1);
        end
        else if (area_start_column_wr_in)
        begin
          area_reg[sel_reg].start <= start_clamped;
          area_reg[sel_reg].width <= fit_width(area_reg[sel_reg].width, start_clamped, others_sum);
        end
        else if (area_pixel_width_wr_in)
        begin
          area_reg[sel_reg].width <= fit_width(area_pixel_width_in, area_reg[sel_reg].start, others_sum);
        end
      end
    end
  end

  count_range_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    area_count_wr_in && !capture_reg |=> count_reg >= 3'h1 && count_reg <= 3'h4)
    else $error("area count out of range");
  refuse_hold_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    capture_reg && cfg_wr |=> cfg_refused_out && $stable(count_reg) && $stable(sel_reg) && $stable(total_sum))
    else $error("area write taken during capture");
  sel_follow_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    !capture_reg && area_count_wr_in && ({1'b0, sel_reg} >= count_new) |=> {1'b0, sel_reg} == $past(count_new) - 3'h1)
    else $error("selector not moved to last valid area");

  // capture control and line fill
  assign take = pix_valid_in && pix_ready_reg;
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      state_reg <= ST_IDLE;
      capture_reg <= 1'b0;
      halt_pend_reg <= 1'b0;
      pix_ready_reg <= 1'b0;
      fill_col_reg <= 14'h0000;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (begin_capture_cmd_in && limits_ok)
          begin
            state_reg <= ST_FILL;
            capture_reg <= 1'b1;
            halt_pend_reg <= 1'b0;
            pix_ready_reg <= 1'b1;
            fill_col_reg <= 14'h0000;
          end
        end
        ST_FILL:
        begin
          if (take && fill_col_reg == aoip_pkg::LAST_COL)
          begin
            state_reg <= ST_EMIT;
            pix_ready_reg <= 1'b0;
            halt_pend_reg <= halt_pend_reg || halt_capture_cmd_in;
          end
          else if (take)
          begin
            fill_col_reg <= fill_col_reg + 14'h0001;
            halt_pend_reg <= halt_pend_reg || halt_capture_cmd_in;
          end
          else if ((halt_capture_cmd_in || halt_pend_reg) && fill_col_reg == 14'h0000)
          begin
            state_reg <= ST_IDLE;
            capture_reg <= 1'b0;
            pix_ready_reg <= 1'b0;
            halt_pend_reg <= 1'b0;
          end
          else if (halt_capture_cmd_in)
          begin
            halt_pend_reg <= 1'b1;
          end
        end
        ST_EMIT:
        begin
          if (push && last_beat)
          begin
            state_reg <= ST_FILL;
            pix_ready_reg <= !(halt_pend_reg || halt_capture_cmd_in);
            // a halt landing on the last beat must still pend, or fill stalls with ready low
            halt_pend_reg <= halt_pend_reg || halt_capture_cmd_in;
            fill_col_reg <= 14'h0000;
          end
          else if (halt_capture_cmd_in)
          begin
            halt_pend_reg <= 1'b1;
          end
        end
        default:
        begin
          state_reg <= ST_IDLE;
          capture_reg <= 1'b0;
          pix_ready_reg <= 1'b0;
        end
      endcase
    end
  end

  total_max_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    capture_reg |-> total_sum >= aoip_pkg::MIN_TOTAL_W && total_sum <= aoip_pkg::MAX_TOTAL_W)
    else $error("packed width above line width");
  total_min_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    state_reg == ST_IDLE && begin_capture_cmd_in && total_sum < aoip_pkg::MIN_TOTAL_W |=> !capture_reg)
    else $error("capture began below minimum total width");
  lane_budget_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    capture_reg |-> lane_bytes(total_sum) <= aoip_pkg::LANE_BYTES_MAX)
    else $error("lane byte budget exceeded");

  // sensor line store
  always_ff @(posedge ref_clk_in)
  begin
    if (take)
    begin
      line_mem[fill_col_reg] <= pix_data_in;
    end
  end

  // read only area columns, area by area
  assign push = (state_reg == ST_EMIT) && fifo_ready;
  assign last_beat = (remain_reg == 15'h0001) && ({1'b0, area_ptr_reg} == count_reg - 3'h1);
  assign ptr_next = area_ptr_reg + 2'h1;
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      area_ptr_reg <= 2'h0;
      rd_col_reg <= 14'h0000;
      remain_reg <= 15'h0000;
      out_col_reg <= 15'h0000;
    end
    else if (state_reg == ST_FILL && take && fill_col_reg == aoip_pkg::LAST_COL)
    begin
      area_ptr_reg <= 2'h0;
      rd_col_reg <= area_reg[0].start;
      remain_reg <= area_reg[0].width;
      out_col_reg <= 15'h0000;
    end
    else if (push)
    begin
      out_col_reg <= out_col_reg + 15'h0001;
      if (remain_reg == 15'h0001)
      begin
        area_ptr_reg <= ptr_next;
        rd_col_reg <= area_reg[ptr_next].start;
        remain_reg <= area_reg[ptr_next].width;
      end
      else
      begin
        rd_col_reg <= rd_col_reg + 14'h0001;
        remain_reg <= remain_reg - 15'h0001;
      end
    end
  end

  // read stays inside the current area
  inside_area_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    push |-> rd_col_reg >= area_reg[area_ptr_reg].start
      && {3'h0, rd_col_reg} < {2'h0, area_reg[area_ptr_reg].start} + {2'h0, area_reg[area_ptr_reg].width})
    else $error("pixel outside area emitted");
  // line starts with first area at column zero
  first_col_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    $rose(state_reg == ST_EMIT) |-> area_ptr_reg == 2'h0 && out_col_reg == 15'h0000
      && rd_col_reg == area_reg[0].start)
    else $error("packed line not started at first area");
  // last beat closes the summed width
  last_width_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    push && last_beat |-> {2'h0, out_col_reg} == total_sum - 17'h00001 ##1 state_reg == ST_FILL)
    else $error("packed width differs from summed areas");

  // beat into the output buffer
  assign beat.pix = line_mem[rd_col_reg];
  assign beat.lane = out_col_reg[aoip_pkg::LANE_BITS-1:0];
  assign beat.last = last_beat;

  aoip_fifo #(
    .WIDTH($bits(aoip_pkg::aoip_beat_t)),
    .DEPTH(aoip_pkg::FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(state_reg == ST_EMIT),
    .in_data_in(beat),
    .in_ready_out(fifo_ready),
    .out_valid_out(out_valid_out),
    .out_data_out(out_beat_out),
    .out_ready_in(out_ready_in)
  );

  // readback of the selected area and packed width
  always_ff @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      start_rb_reg <= aoip_pkg::RST_START;
      width_rb_reg <= aoip_pkg::RST_WIDTH_FIRST;
      packed_reg <= aoip_pkg::LINE_WIDTH;
    end
    else
    begin
      start_rb_reg <= area_reg[sel_reg].start;
      width_rb_reg <= area_reg[sel_reg].width;
      packed_reg <= total_sum;
    end
  end

  width_step_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    area_pixel_width_out[4:0] == 5'h00 && area_pixel_width_out >= 15'h0060)
    else $error("area width off step or below minimum");
  fit_line_a: assert property (@(posedge ref_clk_in) disable iff (!reset_n_in)
    area_start_column_out <= 14'h3fa0 && {1'b0, area_start_column_out} + area_pixel_width_out <= 15'h4000)
    else $error("area runs past sensor line");

  assign pix_ready_out = pix_ready_reg;
  assign capture_state_out = capture_reg;
  assign cfg_refused_out = refused_reg;
  assign area_count_out = count_reg;
  assign area_index_select_out = sel_reg;
  assign area_start_column_out = start_rb_reg;
  assign area_pixel_width_out = width_rb_reg;
  assign packed_width_out = packed_reg;
endmodule

//--- verif/aoip_grabber.sv
module aoip_grabber (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic [1:0] mode_in,
  input wire logic [16:0] line_width_in,
  input wire logic valid_in,
  input wire aoip_pkg::aoip_beat_t beat_in,
  output logic ready_out,
  output logic line_err_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] taken;
  logic phase = 1'b0;

  // ready pattern: 0 prompt, 1 every other cycle, 2 stalled
  always @(negedge ref_clk_in)
  begin
    phase = ~phase;
    ready_out = (mode_in == 2'h0) || (mode_in == 2'h1 && phase);
  end

  always @(posedge ref_clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      taken <= 17'h00000;
      line_err_out <= 1'b0;
    end
    else if (valid_in && ready_out)
    begin
      taken <= beat_in.last ? 17'h00000 : taken + 17'h00001;
      if (beat_in.last && (taken + 17'h00001) != line_width_in)
        line_err_out <= 1'b1;
    end
  end
endmodule

//--- verif/test_line_area_of_interest_packer.sv
module test_line_area_of_interest_packer;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in;
  logic reset_n_in;
  logic [3:0] wr_v;
  logic [14:0] wd;
  logic [1:0] cmd;
  logic pix_valid_in;
  logic [11:0] pix_data_in;
  logic pix_ready_out;
  logic out_valid_out;
  aoip_pkg::aoip_beat_t out_beat_out;
  logic out_ready_in;
  logic capture_state_out;
  logic cfg_refused_out;
  logic [2:0] area_count_out;
  logic [1:0] area_index_select_out;
  logic [13:0] area_start_column_out;
  logic [14:0] area_pixel_width_out;
  logic [16:0] packed_width_out;
  logic [1:0] gmode = 2'h2;
  logic grab_err;
  logic feed = 1'b0;
  logic [14:0] col = 15'h0000;
  int errors = 0;
  int compares = 0;
  int beat_idx = 0;
  int refused_n = 0;
  int total = 0;
  int lane_n[4] = '{0, 0, 0, 0};
  int area_s[2] = '{64, 320};
  int area_w[2] = '{512, 512};

  aoip_packer u_dut (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .area_count_wr_in(wr_v[0]),
    .area_count_in(wd[2:0]),
    .area_index_select_wr_in(wr_v[1]),
    .area_index_select_in(wd[1:0]),
    .area_start_column_wr_in(wr_v[2]),
    .area_start_column_in(wd[13:0]),
    .area_pixel_width_wr_in(wr_v[3]),
    .area_pixel_width_in(wd),
    .begin_capture_cmd_in(cmd[0]),
    .halt_capture_cmd_in(cmd[1]),
    .pix_valid_in(pix_valid_in),
    .pix_data_in(pix_data_in),
    .pix_ready_out(pix_ready_out),
    .out_valid_out(out_valid_out),
    .out_beat_out(out_beat_out),
    .out_ready_in(out_ready_in),
    .capture_state_out(capture_state_out),
    .cfg_refused_out(cfg_refused_out),
    .area_count_out(area_count_out),
    .area_index_select_out(area_index_select_out),
    .area_start_column_out(area_start_column_out),
    .area_pixel_width_out(area_pixel_width_out),
    .packed_width_out(packed_width_out)
  );

  aoip_grabber u_grab (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .mode_in(gmode),
    .line_width_in(packed_width_out),
    .valid_in(out_valid_out),
    .beat_in(out_beat_out),
    .ready_out(out_ready_in),
    .line_err_out(grab_err)
  );

  // clock source
  initial
  begin
    ref_clk_in = 1'b0;
    forever #12.5 ref_clk_in = ~ref_clk_in;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // one setting write: 0 count, 1 select, 2 start, 3 width; outputs settle after
  task automatic wr(input int f, input logic [14:0] v);
    @(negedge ref_clk_in);
    wr_v = 4'h1 << f;
    wd = v;
    @(negedge ref_clk_in);
    wr_v = 4'h0;
    repeat (3) @(negedge ref_clk_in);
  endtask

  task automatic pulse(input int c);
    @(negedge ref_clk_in);
    cmd = 2'h1 << c;
    @(negedge ref_clk_in);
    cmd = 2'h0;
    repeat (2) @(negedge ref_clk_in);
  endtask

  // packed column k maps back to a sensor column
  function automatic int exp_col(input int k);
    int base;
    base = 0;
    for (int a = 0; a < 2; a++)
    begin
      if (k >= base && k < base + area_w[a])
        return area_s[a] + k - base;
      base += area_w[a];
    end
    return 0;
  endfunction

  // pixel source, one column per accepted cycle
  always @(posedge ref_clk_in)
    if (pix_valid_in && pix_ready_out)
      col <= col + 15'h0001;
  always @(negedge ref_clk_in)
  begin
    pix_valid_in = feed && (col < 15'h4000);
    pix_data_in = col[11:0];
  end

  // beat monitor and refusal counter
  always @(posedge ref_clk_in)
  begin
    if (cfg_refused_out === 1'b1)
      refused_n++;
    if (reset_n_in === 1'b1 && out_valid_out === 1'b1 && out_ready_in)
    begin
      check(out_beat_out.pix, 32'(12'(exp_col(beat_idx))));
      check(out_beat_out.lane, 32'(beat_idx % 4));
      check(out_beat_out.last, 32'(beat_idx == total - 1));
      lane_n[out_beat_out.lane]++;
      beat_idx++;
    end
  end

  task automatic t_reset_values();
    check(area_count_out, 32'h1);
    check(area_index_select_out, 32'h0);
    check(area_start_column_out, 32'h0);
    check(area_pixel_width_out, 32'h4000);
    check(packed_width_out, 32'h4000);
    check(capture_state_out, 32'h0);
    check(out_valid_out, 32'h0);
  endtask

  task automatic t_count_select();
    for (int i = 1; i < 5; i++)
    begin
      wr(0, 15'(i));
      check(area_count_out, 32'(i));
    end
    wr(0, 15'h0000);
    check(area_count_out, 32'h1);
    wr(0, 15'h0007);
    check(area_count_out, 32'h4);
    wr(1, 15'h0003);
    check(area_index_select_out, 32'h3);
    wr(0, 15'h0002);
    check(area_index_select_out, 32'h1);
    wr(1, 15'h0003);
    check(area_index_select_out, 32'h1);
    wr(0, 15'h0001);
    check(area_index_select_out, 32'h0);
  endtask

  task automatic t_fit_widths();
    wr(0, 15'h0002);
    wr(2, 15'h1000);
    check(area_pixel_width_out, 32'h3000);
    wr(3, 15'h4e20);
    check(area_pixel_width_out, 32'h3000);
    wr(3, 15'h0064);
    check(area_pixel_width_out, 32'h3a0);
    check(packed_width_out, 32'h400);
    wr(1, 15'h0001);
    wr(3, 15'h00c8);
    check(area_pixel_width_out, 32'hc0);
    wr(3, 15'h0028);
    check(area_pixel_width_out, 32'h60);
    wr(2, 15'h3fff);
    check(area_start_column_out, 32'h3fa0);
    check(area_pixel_width_out, 32'h60);
    wr(1, 15'h0000);
    check(area_pixel_width_out, 32'h3a0);
  endtask

  task automatic t_pack_line();
    int seq_f[10] = '{0, 1, 2, 3, 0, 1, 2, 3, 1, 3};
    int seq_v[10] = '{1, 0, 64, 1024, 2, 1, 320, 512, 0, 512};
    int n;
    // areas set while capture is stopped
    for (int i = 0; i < 10; i++)
      wr(seq_f[i], 15'(seq_v[i]));
    total = 1024;
    check(packed_width_out, 32'h400);
    pulse(0);
    check(capture_state_out, 32'h1);
    wr(3, 15'h0060);
    check(refused_n, 32'h1);
    check(area_pixel_width_out, 32'h200);
    feed = 1'b1;
    n = 0;
    while (col != 15'h4000 && n < 20000)
    begin
      @(negedge ref_clk_in);
      n++;
    end
    pulse(1);
    repeat (50) @(negedge ref_clk_in);
    check(capture_state_out, 32'h1);
    check(pix_ready_out, 32'h0);
    gmode = 2'h1;
    n = 0;
    while (beat_idx < total && n < 5000)
    begin
      @(negedge ref_clk_in);
      if (beat_idx >= 512)
        gmode = 2'h0;
      n++;
    end
    repeat (6) @(negedge ref_clk_in);
    check(capture_state_out, 32'h0);
    check(beat_idx, 32'h400);
    for (int l = 0; l < 4; l++)
      check(lane_n[l], 32'h100);
    check(grab_err, 32'h0);
  endtask

  // watchdog
  initial
  begin
    repeat (40000) @(posedge ref_clk_in);
    errors++;
    finish_test();
  end

  // main sequence
  initial
  begin
    reset_n_in = 1'b0;
    wr_v = 4'h0;
    wd = 15'h0000;
    cmd = 2'h0;
    repeat (2) @(negedge ref_clk_in);
    reset_n_in = 1'b1;
    t_reset_values();
    t_count_select();
    t_fit_widths();
    t_pack_line();
    finish_test();
  end
endmodule
